// File: rtl/or_shift_move_alu_ops.v
// Execution datapath for OR-into-file, logical shift left and move-test operations
//
// How it works
// - The OR operation combines the working register with the addressed file register and touches only zero.
// - Destination select 0 sends the result to the working register, 1 writes it back to the file register.
// - The shift-left operation moves source bits 6:0 up to bits 7:1 and puts zero in bit 0.
// - The shift-left operation copies source bit 7 into carry and sets zero from the shifted byte.
// - The move operation passes the file register value unchanged to the selected destination.
// - The move operation sets zero from the value and, with select 1, leaves the file register as it was.
//
// An operation is taken on the edge where op_valid is high and the enable bit is set.
// All effects (working register, flags, file write strobe) appear one cycle later.
//
// Added by the designer: the placing of the registers and the strobed register port.
module or_shift_move_alu_ops
#(
   parameter COUNT_W = 16
)
(
   input  wire               clk,
   input  wire               rst,
   // Decoder side
   input  wire               op_valid,
   input  wire [1:0]         op_code,
   input  wire [6:0]         file_addr,
   input  wire               dest_sel,
   input  wire [7:0]         file_rdata,
   // File register array write port
   output reg                file_we,
   output reg  [6:0]         file_waddr,
   output reg  [7:0]         file_wdata,
   // Core-visible state
   output reg  [7:0]         work_reg,
   output reg                carry_flag,
   output reg                zero_flag,
   output reg                op_done,
   // Register port
   input  wire [7:0]         reg_addr,
   input  wire [31:0]        reg_wdata,
   input  wire               reg_wr,
   input  wire               reg_rd,
   output reg  [31:0]        reg_rdata
);

`include "alu_ops_defines.vh"

   wire [7:0]         alu_result;
   wire               alu_carry_write;
   wire               alu_carry_val;
   wire               alu_zero_val;
   wire               alu_op_legal;
   wire               take_op;
   wire               exec_op;
   wire               to_file;
   wire               wr_work;
   wire               wr_status;
   wire               wr_control;
   wire               wr_count;

   reg                enable_q;
   reg                bad_op_q;
   reg  [COUNT_W-1:0] op_count_q;
   reg  [7:0]         last_result_q;
   reg  [7:0]         work_d;
   reg                carry_d;
   reg                zero_d;
   reg                bad_op_d;
   reg  [31:0]        rd_mux;

   // Result logic works straight off the current working register
   alu_result_unit u_result
   (
      .op_code     (op_code),
      .work_val    (work_reg),
      .file_val    (file_rdata),
      .result      (alu_result),
      .carry_write (alu_carry_write),
      .carry_val   (alu_carry_val),
      .zero_val    (alu_zero_val),
      .op_legal    (alu_op_legal)
   );

   // Request qualification; an unused code is taken but only sets the sticky bad-op status bit
   assign take_op = op_valid & enable_q;
   assign exec_op = take_op & alu_op_legal;
   assign to_file = exec_op & (dest_sel == `DEST_FILE);

   // Register write decode
   assign wr_work    = reg_wr & (reg_addr == `REG_WORK);
   assign wr_status  = reg_wr & (reg_addr == `REG_STATUS);
   assign wr_control = reg_wr & (reg_addr == `REG_CONTROL);
   assign wr_count   = reg_wr & (reg_addr == `REG_OP_COUNT);

   // Next working register: an executing operation wins over a software write
   // so that an instruction result is never lost to a racing register access
   always @*
   begin
      work_d = work_reg;
      if (exec_op && (dest_sel == `DEST_WORK))
      begin
         work_d = alu_result;
      end
      else if (wr_work)
      begin
         work_d = reg_wdata[7:0];
      end
   end

   // Next flags: same priority as the working register
   always @*
   begin
      carry_d  = carry_flag;
      zero_d   = zero_flag;
      bad_op_d = bad_op_q;
      if (wr_status)
      begin
         carry_d = reg_wdata[`STATUS_CARRY_BIT];
         zero_d  = reg_wdata[`STATUS_ZERO_BIT];
         if (reg_wdata[`STATUS_BAD_OP_BIT])
         begin
            bad_op_d = 1'b0;                 // Write one to clear
         end
      end
      if (exec_op)
      begin
         zero_d = alu_zero_val;
         if (alu_carry_write)
         begin
            carry_d = alu_carry_val;
         end
      end
      if (take_op && !alu_op_legal)
      begin
         bad_op_d = 1'b1;                    // Set wins over the clear
      end
   end

   // Core state registers
   always @(posedge clk)
   begin
      if (rst)
      begin
         work_reg   <= `WORK_RESET;
         carry_flag <= 1'b0;
         zero_flag  <= 1'b0;
         bad_op_q   <= 1'b0;
      end
      else
      begin
         work_reg   <= work_d;
         carry_flag <= carry_d;
         zero_flag  <= zero_d;
         bad_op_q   <= bad_op_d;
      end
   end

   // File write-back strobe; a move with select 1 writes back the same byte,
   // so the file content stays as it was and only zero changes
   always @(posedge clk)
   begin
      if (rst)
      begin
         file_we    <= 1'b0;
         file_waddr <= 7'h00;
         file_wdata <= 8'h00;
      end
      else
      begin
         file_we <= to_file;
         if (to_file)
         begin
            file_waddr <= file_addr;
            file_wdata <= alu_result;
         end
      end
   end

   // Completion pulse and bookkeeping
   always @(posedge clk)
   begin
      if (rst)
      begin
         op_done       <= 1'b0;
         op_count_q    <= {COUNT_W{1'b0}};
         last_result_q <= `LAST_RESULT_RESET;
      end
      else
      begin
         op_done <= exec_op;
         if (exec_op)
         begin
            op_count_q    <= op_count_q + {{(COUNT_W-1){1'b0}}, 1'b1};  // Wraps silently
            last_result_q <= alu_result;
         end
         else if (wr_count)
         begin
            op_count_q <= {COUNT_W{1'b0}};
         end
      end
   end

   // Control register; disabling stalls execution without losing state
   always @(posedge clk)
   begin
      if (rst)
      begin
         enable_q <= 1'b1;
      end
      else if (wr_control)
      begin
         enable_q <= reg_wdata[`CONTROL_ENABLE_BIT];
      end
   end

   // Read multiplexer; unmapped addresses read as zero
   always @*
   begin
      rd_mux = 32'h0000_0000;
      case (reg_addr)
         `REG_WORK:
         begin
            rd_mux[7:0] = work_reg;
         end
         `REG_STATUS:
         begin
            rd_mux[`STATUS_CARRY_BIT]  = carry_flag;
            rd_mux[`STATUS_ZERO_BIT]   = zero_flag;
            rd_mux[`STATUS_BAD_OP_BIT] = bad_op_q;
         end
         `REG_CONTROL:
         begin
            rd_mux[`CONTROL_ENABLE_BIT] = enable_q;
         end
         `REG_OP_COUNT:
         begin
            rd_mux[COUNT_W-1:0] = op_count_q;
         end
         `REG_LAST_RESULT:
         begin
            rd_mux[7:0] = last_result_q;
         end
         default:
         begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge clk)
   begin
      if (rst)
      begin
         reg_rdata <= 32'h0000_0000;
      end
      else if (reg_rd)
      begin
         reg_rdata <= rd_mux;
      end
      else
      begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule // or_shift_move_alu_ops

// File: include/alu_ops_defines.vh
// Constants of the OR, shift-left and move-test execution datapath
`ifndef ALU_OPS_DEFINES_VH
`define ALU_OPS_DEFINES_VH

// Operation codes presented by the instruction decoder
`define OP_OR_WORK_INTO_FILE   2'h0
`define OP_SHIFT_LEFT_LOGICAL  2'h1
`define OP_MOVE_FILE_TEST      2'h2
`define OP_UNUSED              2'h3

// Destination select values
`define DEST_WORK              1'h0
`define DEST_FILE              1'h1

// Register port byte addresses
`define REG_WORK               8'h00
`define REG_STATUS             8'h04
`define REG_CONTROL            8'h08
`define REG_OP_COUNT           8'h0C
`define REG_LAST_RESULT        8'h10

// Status register field positions
`define STATUS_CARRY_BIT       0
`define STATUS_ZERO_BIT        1
`define STATUS_BAD_OP_BIT      7

// Control register field positions
`define CONTROL_ENABLE_BIT     0

// Reset values
`define WORK_RESET             8'h00
`define STATUS_RESET           8'h00
`define CONTROL_RESET          8'h01
`define OP_COUNT_RESET         16'h0000
`define LAST_RESULT_RESET      8'h00

`endif

// File: rtl/alu_result_unit.v
// Combinational result and flag logic for the three byte-wide operations
module alu_result_unit
(
   input  wire [1:0] op_code,
   input  wire [7:0] work_val,
   input  wire [7:0] file_val,
   output reg  [7:0] result,
   output reg        carry_write,
   output reg        carry_val,
   output reg        zero_val,
   output reg        op_legal
);

`include "alu_ops_defines.vh"

   // True when all eight bits are clear
   function is_zero;
      input [7:0] v;
      begin
         is_zero = (v == 8'h00);
      end
   endfunction

   // Per-operation result; only the shift touches carry
   always @*
   begin
      result      = 8'h00;
      carry_write = 1'b0;
      carry_val   = 1'b0;
      op_legal    = 1'b1;
      case (op_code)
         `OP_OR_WORK_INTO_FILE:
         begin
            result = work_val | file_val;
         end
         `OP_SHIFT_LEFT_LOGICAL:
         begin
            result      = {file_val[6:0], 1'b0};
            carry_write = 1'b1;
            carry_val   = file_val[7];
         end
         `OP_MOVE_FILE_TEST:
         begin
            result = file_val;
         end
         default:
         begin
            op_legal = 1'b0;
         end
      endcase
      zero_val = is_zero(result);
   end

endmodule // alu_result_unit

// File: verif/file_reg_model.sv
// Behavioural file register array behind the decoder
module file_reg_model
(
   input  wire       clk,
   input  wire [6:0] file_addr,
   input  wire       file_we,
   input  wire [6:0] file_waddr,
   input  wire [7:0] file_wdata,
   output wire [7:0] file_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:127];
   // Read is combinational so the operand is current in the request cycle
   assign file_rdata = mem[file_addr];
   // Write port; a lost write shows up in later operands
   always @(posedge clk)
   begin
      if (file_we)
         mem[file_waddr] <= file_wdata;
   end
endmodule // file_reg_model

// File: verif/alu_ops_sva.sv
// Checker for the operation port of the datapath
module alu_ops_sva
#(
   parameter COUNT_W = 16
)
(
   input wire       clk,
   input wire       rst,
   input wire       op_valid,
   input wire [1:0] op_code,
   input wire       dest_sel,
   input wire [7:0] file_rdata,
   input wire       file_we,
   input wire [7:0] file_wdata,
   input wire [7:0] work_reg,
   input wire       carry_flag,
   input wire       zero_flag,
   input wire       op_done
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Every property starts at a taken request; the done pulse excludes refused ones
   property p_or;
      op_valid && op_code == 2'h0 ##1 op_done |-> $stable(carry_flag) &&
         ($past(dest_sel) ? file_wdata : work_reg) == ($past(work_reg) | $past(file_rdata));
   endproperty
   a_or: assert property (p_or) else $error("or result wrong");
   property p_dest;
      op_valid && op_code != 2'h3 ##1 op_done |-> file_we == $past(dest_sel);
   endproperty
   a_dest: assert property (p_dest) else $error("destination wrong");
   property p_shl;
      op_valid && op_code == 2'h1 ##1 op_done |-> ($past(dest_sel) ? file_wdata : work_reg) == $past(file_rdata) << 1;
   endproperty
   a_shl: assert property (p_shl) else $error("shift result wrong");
   // Bit 7 test by magnitude, since a slice of a past value is not allowed
   property p_shc;
      op_valid && op_code == 2'h1 ##1 op_done |-> carry_flag == ($past(file_rdata) >= 8'h80);
   endproperty
   a_shc: assert property (p_shc) else $error("shift carry wrong");
   property p_mov;
      op_valid && op_code == 2'h2 ##1 op_done |-> ($past(dest_sel) ? file_wdata : work_reg) == $past(file_rdata);
   endproperty
   a_mov: assert property (p_mov) else $error("move result wrong");
   property p_tst;
      op_valid && op_code == 2'h2 && dest_sel ##1 op_done |-> $stable(work_reg) && $stable(carry_flag);
   endproperty
   a_tst: assert property (p_tst) else $error("test changed state");
   property p_zero;
      op_valid && op_code != 2'h3 ##1 op_done |-> zero_flag == (($past(dest_sel) ? file_wdata : work_reg) == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
endmodule // alu_ops_sva
bind or_shift_move_alu_ops alu_ops_sva #(.COUNT_W(COUNT_W)) sva_i (.clk(clk), .rst(rst), .op_valid(op_valid),
   .op_code(op_code), .dest_sel(dest_sel), .file_rdata(file_rdata), .file_we(file_we), .file_wdata(file_wdata),
   .work_reg(work_reg), .carry_flag(carry_flag), .zero_flag(zero_flag), .op_done(op_done));

// File: verif/test_or_shift_move_alu_ops.sv
// Self-checking bench for the OR, shift-left and move-test datapath
module test_or_shift_move_alu_ops;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, rst = 1, op_valid = 0, dest_sel = 0, reg_wr = 0, reg_rd = 0;
   logic [1:0]  op_code = 0;
   logic [6:0]  file_addr = 0, file_waddr;
   logic [7:0]  reg_addr = 0, file_rdata, file_wdata, work_reg;
   logic [31:0] reg_wdata = 0, reg_rdata;
   logic        file_we, carry_flag, zero_flag, op_done;
   int          err_total = 0, checked = 0;
   or_shift_move_alu_ops or_shift_move_alu_ops_i (.clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
      .file_addr(file_addr), .dest_sel(dest_sel), .file_rdata(file_rdata), .file_we(file_we),
      .file_waddr(file_waddr), .file_wdata(file_wdata), .work_reg(work_reg), .carry_flag(carry_flag),
      .zero_flag(zero_flag), .op_done(op_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   file_reg_model file_reg_model_i (.clk(clk), .file_addr(file_addr), .file_we(file_we), .file_waddr(file_waddr),
      .file_wdata(file_wdata), .file_rdata(file_rdata));
   // 50 MHz clock
   initial forever #10 clk = ~clk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      checked++;
      if (g !== e)
      begin
         err_total++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   // Register port cycles; a strobe lasts one cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1;
      @(posedge clk);
      reg_wr <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge clk);
      reg_rd <= 0;
      #1 chk(reg_rdata, e, "register read");
   endtask
   // Preload lands after any pending file write, then one request; returns where effects show
   task automatic op(input logic [1:0] c, input logic [6:0] a, input logic d, input logic [7:0] f);
      @(posedge clk);
      #1 file_reg_model_i.mem[a] = f;
      @(posedge clk);
      op_valid <= 1;
      op_code <= c;
      file_addr <= a;
      dest_sel <= d;
      @(posedge clk);
      op_valid <= 0;
      #1;
   endtask
   task automatic t_reset();
      rd(8'h00, 0);
      rd(8'h04, 0);
      rd(8'h08, 1);
      rd(8'h0C, 0);
   endtask
   task automatic t_or();
      wr(8'h00, 'h0F);
      wr(8'h04, 1);
      op(2'h0, 5, 1, 8'hF0);
      chk({file_wdata, work_reg, file_we, zero_flag, carry_flag}, {8'hFF, 8'h0F, 3'h5}, "or");
      wr(8'h00, 0);
      op(2'h0, 6, 0, 8'h00);
      chk({work_reg, file_we, zero_flag, carry_flag}, {8'h00, 3'h3}, "or zero");
   endtask
   task automatic t_shl();
      op(2'h1, 8, 0, 8'h81);
      chk({work_reg, file_we, zero_flag, carry_flag}, {8'h02, 3'h1}, "shift");
      op(2'h1, 9, 1, 8'h80);
      chk({file_wdata, work_reg, file_we, zero_flag, carry_flag}, {8'h00, 8'h02, 3'h7}, "shift z");
   endtask
   task automatic t_mov();
      op(2'h2, 10, 1, 8'h00);
      chk({file_wdata, work_reg, file_we, zero_flag, carry_flag}, {8'h00, 8'h02, 3'h7}, "test");
      op(2'h2, 11, 0, 8'hA5);
      chk({work_reg, file_we, zero_flag, carry_flag}, {8'hA5, 3'h1}, "move");
      // Nonzero test byte, so a stale write-back word cannot pass by accident
      op(2'h2, 13, 1, 8'h3C);
      chk({file_wdata, file_waddr, work_reg, file_we, zero_flag, carry_flag}, {8'h3C, 7'h0D, 8'hA5, 3'h5}, "test byte");
   endtask
   // Disabled and illegal requests leave no trace but the sticky status bit
   task automatic t_ref();
      rd(8'h0C, 7);
      wr(8'h08, 0);
      op(2'h2, 12, 0, 8'h11);
      chk({op_done, work_reg}, {1'h0, 8'hA5}, "disabled op ran");
      wr(8'h08, 1);
      op(2'h3, 12, 0, 8'h11);
      chk(op_done, 0, "bad op ran");
      rd(8'h04, 'h81);
      rd(8'h10, 'h3C);
      chk(file_reg_model_i.mem[13], 'h3C, "tested byte altered");
      // Write one clears the sticky bit; carry and zero take the written bits
      wr(8'h04, 'h80);
      rd(8'h04, 0);
      wr(8'h0C, 0);
      rd(8'h0C, 0);
      rd(8'h20, 0);
   endtask
   task final_report();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 0;
      t_reset();
      t_or();
      t_shl();
      t_mov();
      t_ref();
      final_report();
   end
   // Hang guard
   initial
   begin
      repeat (4000) @(posedge clk);
      err_total++;
      final_report();
   end
endmodule // test_or_shift_move_alu_ops
